// ==== verilog/olt_engine.sv ====
// Loop-back test engine: registers, frame generator and result counters.
//
// Behaviour
// - Zero loop count write clears maintenance and center result counters.
// - On center, writing N from 1 to 100 sends exactly N frames.
// - Loop count resets to seven.
// - Codes 00,01,02,04 pick 55AA frames: 64/1518 unicast/broadcast.
// - Codes 08,10,20,40 pick 0F0F frames: 64/1518 unicast/broadcast.
// - Code 80 gives 1518-byte broadcast FF00 frames; others give 64-byte unicast 55AA frames.
// - Unicast DA is station address with last byte plus one, rising per frame.
// - SA is the station address unchanged; type field is 0x0800.
// - Patterns, frame generation and result counters work only on center.
// - Eight-bit counter counts returned frames with CRC errors.
// - Eight-bit counter counts frames not returned in time.
// - Eight-bit counter counts frames returned good.
// - Status bits 5:4 hold a writable model field.
// - Status bit 3 sets on loop-stop indication, clears when read.
// - Status bit 2 sets on long-loop timer expiry, clears when read.
// - Status bit 1 sets on reply-wait expiry, clears when read.
// - Status bit 0 reads one while the fibre link is down.
// - Status bits 7:6 show a read-only hardware version.
// - Valid-transmit counter counts each valid maintenance frame sent.
// - Receive counter needs good CRC, valid opcode and valid direction.
`timescale 1ns/1ps
`include "olt_consts.svh"
module olt_engine import olt_pkg::*; #(
  parameter int REPLY_WAIT_CYC = `OLT_REPLY_WAIT_CYC  // Reply wait in cycles.
) (
  input  wire logic        clk_sys,           // System clock, 100 MHz.
  input  wire logic        rst,               // Synchronous reset.
  input  wire logic        ce,                // Clock enable.
  input  wire logic        center_side,       // Converter is center side.
  input  wire logic [47:0] station_addr,      // Station MAC address.
  input  wire logic [7:0]  reg_addr,          // Register address.
  input  wire logic        reg_wr_en,         // Register write strobe.
  input  wire logic [7:0]  reg_wdata,         // Register write data.
  input  wire logic        reg_rd_en,         // Register read strobe.
  output logic      [7:0]  reg_rdata,         // Read data, one cycle later.
  output logic             tx_valid,          // Frame byte valid.
  input  wire logic        tx_ready,          // Link takes byte.
  output logic      [7:0]  tx_data,           // Frame byte.
  output logic             tx_last,           // Last byte of frame.
  input  wire logic        ret_good,          // Loop frame returned good.
  input  wire logic        ret_crc_err,       // Loop frame returned bad CRC.
  input  wire logic        mnt_tx_sent,       // Maintenance frame sent.
  input  wire logic        mnt_rx_crc_ok,     // Received frame CRC good.
  input  wire logic        mnt_rx_op_ok,      // Received opcode valid.
  input  wire logic        mnt_rx_dir_ok,     // Received direction valid.
  input  wire logic        mnt_rx_done,       // Maintenance frame received.
  input  wire logic        loop_stop_ind,     // Loop-mode-stop frame seen.
  input  wire logic        long_loop_timer,   // Long-loop timer expired.
  input  wire logic        reply_wait_timer,  // Reply-wait timer expired.
  input  wire logic        fibre_link_down,   // Fibre port has no link.
  output logic             loop_busy          // Burst in progress.
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic [7:0] loop_count_field_r;
  logic [7:0] pattern_select_field_r;
  logic [1:0] model_r;
  logic [3:1] flag_r;
  logic       start_pend_r;

  wire wr_cnt    = ce && reg_wr_en && (reg_addr == `OLT_ADDR_LOOP_COUNT);
  wire wr_pat    = ce && reg_wr_en && (reg_addr == `OLT_ADDR_PATTERN);
  wire wr_status = ce && reg_wr_en && (reg_addr == `OLT_ADDR_STATUS);
  wire rd_status = ce && reg_rd_en && (reg_addr == `OLT_ADDR_STATUS);
  wire cnt_zero  = (reg_wdata == 8'h00);
  wire clr_all   = wr_cnt && cnt_zero;
  wire clr_res   = clr_all && center_side;
  wire start_req = wr_cnt && !cnt_zero && center_side;

  // Hardware events win over the clearing read in the same cycle.
  wire [3:1] flag_set = {loop_stop_ind, long_loop_timer, reply_wait_timer};
  wire [3:1] flag_nxt = flag_set | (rd_status ? 3'b000 : flag_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loop_count_field_r     <= `OLT_LOOP_COUNT_RST;
      pattern_select_field_r <= `OLT_PATTERN_RST;
      model_r                <= 2'b00;
      flag_r                 <= 3'b000;
    end else if (ce) begin
      if (wr_cnt) begin
        loop_count_field_r <= reg_wdata;
      end
      if (wr_pat) begin
        pattern_select_field_r <= reg_wdata;
      end
      if (wr_status) begin
        model_r <= reg_wdata[`OLT_ST_MODEL_HI:`OLT_ST_MODEL_LO];
      end
      flag_r <= flag_nxt;
    end
  end

  // ****************************************************************
  // Counters
  // ****************************************************************
  logic [7:0] crc_cnt;
  logic [7:0] to_cnt;
  logic [7:0] good_cnt;
  logic [7:0] mtx_cnt;
  logic [7:0] mrx_cnt;
  logic       timeout_hit;

  wire inc_crc  = center_side && ret_crc_err;
  wire inc_good = center_side && ret_good;
  wire inc_mrx  = mnt_rx_done && mnt_rx_crc_ok
                  && mnt_rx_op_ok && mnt_rx_dir_ok;

  olt_sat_cnt u_crc_cnt (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .clr(clr_res), .inc(inc_crc), .cnt_r(crc_cnt));

  olt_sat_cnt u_to_cnt (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .clr(clr_res), .inc(timeout_hit), .cnt_r(to_cnt));

  olt_sat_cnt u_good_cnt (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .clr(clr_res), .inc(inc_good), .cnt_r(good_cnt));

  olt_sat_cnt u_mtx_cnt (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .clr(clr_all), .inc(mnt_tx_sent), .cnt_r(mtx_cnt));

  olt_sat_cnt u_mrx_cnt (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .clr(clr_all), .inc(inc_mrx), .cnt_r(mrx_cnt));

  // ****************************************************************
  // Read data
  // ****************************************************************
  wire [7:0] status_val = {`OLT_HW_VERSION, model_r, flag_r,
                           fibre_link_down};
  logic [7:0] rdata_nxt;

  always_comb begin
    case (reg_addr)
      `OLT_ADDR_LOOP_COUNT: rdata_nxt = loop_count_field_r;
      `OLT_ADDR_PATTERN:    rdata_nxt = pattern_select_field_r;
      `OLT_ADDR_CRC_ERR:    rdata_nxt = crc_cnt;
      `OLT_ADDR_TIMEOUT:    rdata_nxt = to_cnt;
      `OLT_ADDR_GOOD:       rdata_nxt = good_cnt;
      `OLT_ADDR_STATUS:     rdata_nxt = status_val;
      `OLT_ADDR_MNT_TX:     rdata_nxt = mtx_cnt;
      `OLT_ADDR_MNT_RX:     rdata_nxt = mrx_cnt;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd_en) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Frame generator
  // ****************************************************************
  olt_state_t state_r;
  logic [7:0]  frames_left_r;
  logic [7:0]  da_step_r;
  logic [10:0] idx_r;
  logic [7:0]  pat_r;
  logic [31:0] wait_r;
  logic        gen_ready;

  // Unlisted codes fall back to the short unicast 55AA frame.
  wire pat_long  = (pat_r == `OLT_PAT_UC1518_55) ||
                   (pat_r == `OLT_PAT_BC1518_55) ||
                   (pat_r == `OLT_PAT_UC1518_0F) ||
                   (pat_r == `OLT_PAT_BC1518_0F) ||
                   (pat_r == `OLT_PAT_BC1518_FF);
  wire pat_bcast = (pat_r == `OLT_PAT_BC64_55)   ||
                   (pat_r == `OLT_PAT_BC1518_55) ||
                   (pat_r == `OLT_PAT_BC64_0F)   ||
                   (pat_r == `OLT_PAT_BC1518_0F) ||
                   (pat_r == `OLT_PAT_BC1518_FF);
  wire pat_0f    = (pat_r == `OLT_PAT_UC64_0F)   ||
                   (pat_r == `OLT_PAT_UC1518_0F) ||
                   (pat_r == `OLT_PAT_BC64_0F)   ||
                   (pat_r == `OLT_PAT_BC1518_0F);
  wire pat_ff    = (pat_r == `OLT_PAT_BC1518_FF);

  // Frame length excludes the FCS, which the MAC appends.
  wire [10:0] frame_len = pat_long ? `OLT_LEN_LONG : `OLT_LEN_SHORT;
  wire        last_byte = (idx_r == frame_len - 11'd1);
  wire [7:0]  da_last   = station_addr[7:0] + da_step_r;
  wire [47:0] da_val    = pat_bcast ? 48'hFFFF_FFFF_FFFF :
                          {station_addr[47:8], da_last};
  wire        odd_pos   = idx_r[0];
  wire [7:0]  pay_byte  = pat_ff ? (odd_pos ? 8'h00 : 8'hFF) :
                          pat_0f ? 8'h0F :
                          (odd_pos ? 8'hAA : 8'h55);
  logic [7:0] gen_byte;

  always_comb begin
    if (idx_r < 11'd6) begin
      gen_byte = da_val[8'd47 - {idx_r[2:0], 3'b000} -: 8];
    end else if (idx_r < 11'd12) begin
      gen_byte = station_addr[8'd95 - {idx_r[3:0], 3'b000} -: 8];
    end else if (idx_r == 11'd12) begin
      gen_byte = 8'(`OLT_TYPE_LEN >> 8);
    end else if (idx_r == 11'd13) begin
      gen_byte = 8'(`OLT_TYPE_LEN & 16'h00FF);
    end else begin
      gen_byte = pay_byte;
    end
  end

  wire gen_valid = (state_r == OLT_SEND);
  wire gen_push  = ce && gen_valid && gen_ready;
  wire ret_any   = ret_good || ret_crc_err;
  wire wait_out  = (wait_r == 32'd0);
  assign timeout_hit = (state_r == OLT_WAIT) && !ret_any && wait_out;
  assign loop_busy   = (state_r != OLT_IDLE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r       <= OLT_IDLE;
      frames_left_r <= 8'h00;
      da_step_r     <= 8'h00;
      idx_r         <= 11'd0;
      pat_r         <= `OLT_PATTERN_RST;
      wait_r        <= 32'd0;
      start_pend_r  <= 1'b0;
    end else if (ce) begin
      if (start_req && state_r != OLT_IDLE) begin
        start_pend_r <= 1'b1;
      end
      case (state_r)
        OLT_IDLE: begin
          if ((start_req || start_pend_r) && center_side) begin
            state_r       <= OLT_SEND;
            frames_left_r <= start_req ? reg_wdata
                                       : loop_count_field_r;
            pat_r         <= pattern_select_field_r;
            da_step_r     <= 8'h01;
            idx_r         <= 11'd0;
            start_pend_r  <= 1'b0;
          end
        end
        OLT_SEND: begin
          if (gen_push) begin
            idx_r <= idx_r + 11'd1;
            if (last_byte) begin
              state_r <= OLT_WAIT;
              wait_r  <= 32'(REPLY_WAIT_CYC - 1);
            end
          end
        end
        OLT_WAIT: begin
          wait_r <= wait_r - 32'd1;
          if (ret_any || wait_out) begin
            frames_left_r <= frames_left_r - 8'h01;
            da_step_r     <= da_step_r + 8'h01;
            idx_r         <= 11'd0;
            state_r       <= (frames_left_r == 8'h01) ? OLT_IDLE
                                                       : OLT_SEND;
          end
        end
        default: begin
          state_r <= OLT_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  // The buffer lets a receiver stall without losing the byte in flight.
  logic [8:0] buf_out;

  olt_skid_buf u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (gen_valid),
    .in_ready  (gen_ready),
    .in_data   ({last_byte, gen_byte}),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (buf_out)
  );

  assign tx_data = buf_out[7:0];
  assign tx_last = buf_out[8];

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rst_count;
    @(posedge clk_sys) $past(rst) |-> (loop_count_field_r == 8'h07);
  endproperty
  a_rst_count: assert property (p_rst_count)
    else $error("Loop count not seven after reset.");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
      clr_all |=> (mtx_cnt == 8'h00 && mrx_cnt == 8'h00);
  endproperty
  a_clear: assert property (p_clear)
    else $error("Maintenance counters not cleared.");

  property p_terminal_idle;
    @(posedge clk_sys) disable iff (rst)
      (!center_side && state_r == OLT_IDLE && !start_pend_r)
        |=> (state_r == OLT_IDLE);
  endproperty
  a_terminal_idle: assert property (p_terminal_idle)
    else $error("Burst started on terminal side.");

  property p_start;
    @(posedge clk_sys) disable iff (rst)
      (start_req && state_r == OLT_IDLE)
        |=> (state_r == OLT_SEND && frames_left_r == $past(reg_wdata));
  endproperty
  a_start: assert property (p_start)
    else $error("Burst did not start with the written count.");

  property p_sa;
    @(posedge clk_sys) disable iff (rst)
      (gen_valid && idx_r == 11'd11) |-> (gen_byte == station_addr[7:0]);
  endproperty
  a_sa: assert property (p_sa)
    else $error("Source address last byte wrong.");

  property p_flag_set;
    @(posedge clk_sys) disable iff (rst)
      (ce && loop_stop_ind) |=> flag_r[3];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Stop indication flag lost.");

  property p_flag_clr;
    @(posedge clk_sys) disable iff (rst)
      (rd_status && !long_loop_timer) |=> !flag_r[2];
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("Long-loop flag not cleared by read.");

  property p_reply_flag;
    @(posedge clk_sys) disable iff (rst)
      (ce && reply_wait_timer) |=> flag_r[1] && status_val[1];
  endproperty
  a_reply_flag: assert property (p_reply_flag)
    else $error("Reply-wait flag not set.");

  property p_link;
    @(posedge clk_sys) disable iff (rst)
      (ce && reg_rd_en && reg_addr == `OLT_ADDR_STATUS)
        |=> (reg_rdata[0] == $past(fibre_link_down));
  endproperty
  a_link: assert property (p_link)
    else $error("Link-down bit wrong.");

endmodule : olt_engine

// ==== verilog/olt_consts.svh ====
// Offsets, field positions, reset values and timing for the loop-back engine.
`ifndef OLT_CONSTS_SVH
`define OLT_CONSTS_SVH

`define OLT_ADDR_LOOP_COUNT    8'h44
`define OLT_ADDR_PATTERN       8'h45
`define OLT_ADDR_CRC_ERR       8'h46
`define OLT_ADDR_TIMEOUT       8'h47
`define OLT_ADDR_GOOD          8'h48
`define OLT_ADDR_STATUS        8'h49
`define OLT_ADDR_MNT_TX        8'h4D
`define OLT_ADDR_MNT_RX        8'h4E

`define OLT_LOOP_COUNT_RST     8'h07
`define OLT_LOOP_COUNT_MAX     8'h64
`define OLT_PATTERN_RST        8'h00
// Hardware version code shown in status bits 7:6; the value is arbitrary.
`define OLT_HW_VERSION         2'b10

`define OLT_PAT_UC64_55        8'h00
`define OLT_PAT_UC1518_55      8'h01
`define OLT_PAT_BC64_55        8'h02
`define OLT_PAT_BC1518_55      8'h04
`define OLT_PAT_UC64_0F        8'h08
`define OLT_PAT_UC1518_0F      8'h10
`define OLT_PAT_BC64_0F        8'h20
`define OLT_PAT_BC1518_0F      8'h40
`define OLT_PAT_BC1518_FF      8'h80

`define OLT_ST_VERSION_HI      7
`define OLT_ST_VERSION_LO      6
`define OLT_ST_MODEL_HI        5
`define OLT_ST_MODEL_LO        4
`define OLT_ST_STOP_IND        3
`define OLT_ST_LONG_LOOP       2
`define OLT_ST_REPLY_WAIT      1
`define OLT_ST_LINK_DOWN       0

`define OLT_TYPE_LEN           16'h0800
`define OLT_LEN_SHORT          11'h03C
`define OLT_LEN_LONG           11'h5EA
`define OLT_HDR_LEN            11'h00E

`define OLT_CLK_PERIOD_NS      10
`define OLT_REPLY_WAIT_US      1000
`define OLT_REPLY_WAIT_CYC     ((`OLT_REPLY_WAIT_US * 1000) / `OLT_CLK_PERIOD_NS)

`endif

// ==== verilog/olt_pkg.sv ====
// Types shared by the loop-back engine files.
package olt_pkg;

  typedef enum logic [1:0] {
    OLT_IDLE = 2'b00,
    OLT_SEND = 2'b01,
    OLT_WAIT = 2'b10
  } olt_state_t;

endpackage : olt_pkg

// ==== verilog/olt_sat_cnt.sv ====
// Eight-bit saturating event counter with synchronous clear.
`timescale 1ns/1ps
module olt_sat_cnt (
  input  wire logic       clk_sys,  // System clock.
  input  wire logic       rst,      // Synchronous reset, active high.
  input  wire logic       ce,       // Clock enable.
  input  wire logic       clr,      // Clear to zero, wins over inc.
  input  wire logic       inc,      // Count one event.
  output logic      [7:0] cnt_r     // Current count.
);

  wire at_max = (cnt_r == 8'hFF);
  wire [7:0] cnt_nxt = clr ? 8'h00 :
                       (inc && !at_max) ? cnt_r + 8'h01 : cnt_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
    end
  end

  property p_sat_hold;
    @(posedge clk_sys) disable iff (rst)
      (ce && at_max && !clr) |=> (cnt_r == 8'hFF);
  endproperty
  a_sat_hold: assert property (p_sat_hold)
    else $error("Counter left 255 without a clear.");

endmodule : olt_sat_cnt

// ==== verilog/olt_skid_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module olt_skid_buf (
  input  wire logic       clk_sys,   // System clock.
  input  wire logic       rst,       // Synchronous reset, active high.
  input  wire logic       ce,        // Clock enable.
  input  wire logic       in_valid,  // Word offered.
  output logic            in_ready,  // Room for a word.
  input  wire logic [8:0] in_data,   // Byte plus last flag.
  output logic            out_valid, // Word available.
  input  wire logic       out_ready, // Receiver takes word.
  output logic      [8:0] out_data   // Head word.
);

  logic [8:0] mem_r [0:1];
  logic       wr_ptr_r;
  logic       rd_ptr_r;
  logic [1:0] fill_r;

  wire push = ce && in_valid && in_ready;
  wire pop  = ce && out_valid && out_ready;

  assign in_ready  = (fill_r != 2'd2);
  assign out_valid = (fill_r != 2'd0);
  assign out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      fill_r   <= 2'd0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      fill_r   <= fill_r + {1'b0, push} - {1'b0, pop};
    end
  end

  property p_no_overflow;
    @(posedge clk_sys) disable iff (rst)
      (fill_r == 2'd2 && !pop) |=> (fill_r == 2'd2);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("Full buffer lost a word.");

endmodule : olt_skid_buf

// ==== testbench/olt_far_end.sv ====
// Far-end converter model: takes frame bytes with stalls and returns them.
`timescale 1ns/1ps
module olt_far_end (
  input  wire logic       clk_sys,    // System clock.
  input  wire logic       rst,        // Synchronous reset.
  input  wire logic       tx_valid,   // Byte offered.
  input  wire logic       tx_last,    // Last byte of frame.
  input  wire logic [1:0] ret_mode,   // 0 good, 1 bad CRC, 2 lost.
  output logic            tx_ready,   // Byte taken.
  output logic            ret_good,   // Frame came back good.
  output logic            ret_crc_err // Frame came back damaged.
);
  logic [1:0] stall_r;
  logic [3:0] dly_r;
  // Every third cycle is refused, so the buffer must hold a word back.
  assign tx_ready = (stall_r != 2'd2);
  always_ff @(posedge clk_sys) begin
    ret_good    <= 1'b0;
    ret_crc_err <= 1'b0;
    if (rst) begin
      stall_r <= 2'd0;
      dly_r   <= 4'd0;
    end else begin
      stall_r <= (stall_r == 2'd2) ? 2'd0 : stall_r + 2'd1;
      if (tx_valid && tx_ready && tx_last) dly_r <= 4'd5;
      else if (dly_r != 4'd0) dly_r <= dly_r - 4'd1;
      if (dly_r == 4'd1) begin
        ret_good    <= (ret_mode == 2'd0);
        ret_crc_err <= (ret_mode == 2'd1);
      end
    end
  end
endmodule : olt_far_end

// ==== testbench/tb_olt_engine.sv ====
// Self-checking bench for the loop-back test engine.
`timescale 1ns/1ps
`include "olt_consts.svh"
module tb_olt_engine;
  localparam logic [47:0] STA = 48'h0200_1122_33F0;
  logic clk_sys, rst, center_side, reg_wr_en, reg_rd_en, tx_valid, tx_ready;
  logic tx_last, ret_good, ret_crc_err, mnt_tx_sent, mnt_rx_op_ok, ce;
  logic mnt_rx_done, loop_stop_ind, long_loop_timer, reply_wait_timer;
  logic mnt_rx_crc_ok, mnt_rx_dir_ok;
  logic fibre_link_down, loop_busy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data;
  logic [1:0] ret_mode;
  logic [7:0] hdr [4][16];
  int flen [4];
  int fi, bi, error_cnt, comparisons;
  logic [47:0] rows [9] = '{48'h0002_55AA_003C, 48'h0102_55AA_05EA,
    48'h02FF_55AA_003C, 48'h04FF_55AA_05EA, 48'h0802_0F0F_003C,
    48'h1002_0F0F_05EA, 48'h20FF_0F0F_003C, 48'h40FF_0F0F_05EA,
    48'h80FF_FF00_05EA};
  logic [7:0] ra [9] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4D,
    8'h4E, 8'h50};
  logic [7:0] rv [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
    8'h00, 8'h00};

  olt_engine #(.REPLY_WAIT_CYC(20)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .ce(ce), .center_side(center_side), .station_addr(STA),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
    .ret_good(ret_good), .ret_crc_err(ret_crc_err),
    .mnt_tx_sent(mnt_tx_sent), .mnt_rx_crc_ok(mnt_rx_crc_ok),
    .mnt_rx_op_ok(mnt_rx_op_ok), .mnt_rx_dir_ok(mnt_rx_dir_ok),
    .mnt_rx_done(mnt_rx_done), .loop_stop_ind(loop_stop_ind),
    .long_loop_timer(long_loop_timer), .reply_wait_timer(reply_wait_timer),
    .fibre_link_down(fibre_link_down), .loop_busy(loop_busy));
  olt_far_end i_far (.clk_sys(clk_sys), .rst(rst), .tx_valid(tx_valid),
    .tx_last(tx_last), .ret_mode(ret_mode), .tx_ready(tx_ready),
    .ret_good(ret_good), .ret_crc_err(ret_crc_err));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Sampled before the edge's updates land, so bytes are seen as taken.
  always @(posedge clk_sys) if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
    if (bi < 16) hdr[fi % 4][bi] = tx_data;
    if (tx_last === 1'b1) begin
      flen[fi % 4] = bi + 1;
      fi = fi + 1;
      bi = 0;
    end else bi = bi + 1;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick();
    reg_wr_en = 1'b0;
    tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    chk(reg_rdata, e, "register read");
    tick();
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) tick();
    while (loop_busy !== 1'b0) begin
      tick();
      n++;
      if (n > 20000) begin
        $display("MISMATCH t=%0t burst never ended", $time);
        error_cnt++;
        test_done();
      end
    end
  endtask : wait_idle

  initial begin
    {rst, center_side, reg_wr_en, reg_rd_en, mnt_tx_sent} = 5'b11000;
    {ce, mnt_rx_crc_ok, mnt_rx_op_ok, mnt_rx_dir_ok} = 4'b1111;
    {mnt_rx_done, loop_stop_ind} = 2'b00;
    {long_loop_timer, reply_wait_timer, fibre_link_down} = 3'b000;
    {reg_addr, reg_wdata, ret_mode, fi, bi} = '0;
    {error_cnt, comparisons} = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      ret_mode = 2'(i % 3);
      fi = 0;
      wr(`OLT_ADDR_PATTERN, rows[i][47:40]);
      wr(`OLT_ADDR_LOOP_COUNT, 8'h01);
      wait_idle();
      chk(fi, 1, "frame count");
      chk(flen[0], rows[i][15:0], "frame length");
      chk(hdr[0][0], rows[i][39:32], "first DA byte");
      chk(hdr[0][5], rows[i][39:32] == 8'hFF ? 8'hFF : 8'hF1, "DA");
      chk({hdr[0][6], hdr[0][11]}, 16'h02F0, "SA");
      chk({hdr[0][12], hdr[0][13]}, `OLT_TYPE_LEN, "type");
      chk({hdr[0][14], hdr[0][15]}, rows[i][31:16], "payload");
    end
    rd(`OLT_ADDR_CRC_ERR, 8'h03);
    rd(`OLT_ADDR_TIMEOUT, 8'h03);
    rd(`OLT_ADDR_GOOD, 8'h03);
    $display("test pattern rows done");
    ret_mode = 2'd0;
    fi = 0;
    wr(`OLT_ADDR_PATTERN, `OLT_PAT_UC64_55);
    wr(`OLT_ADDR_LOOP_COUNT, 8'h02);
    wait_idle();
    chk(fi, 2, "two frames");
    chk({hdr[0][5], hdr[1][5]}, 16'hF1F2, "DA steps");
    rd(`OLT_ADDR_GOOD, 8'h05);
    $display("test burst of two done");
    mnt_tx_sent = 1'b1;
    mnt_rx_done = 1'b1;
    tick();
    mnt_tx_sent = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {mnt_rx_crc_ok, mnt_rx_op_ok, mnt_rx_dir_ok} = ~(3'b001 << i);
      tick();
    end
    mnt_rx_done = 1'b0;
    rd(`OLT_ADDR_MNT_TX, 8'h01);
    rd(`OLT_ADDR_MNT_RX, 8'h01);
    mnt_tx_sent = 1'b1;
    repeat (260) tick();
    mnt_tx_sent = 1'b0;
    rd(`OLT_ADDR_MNT_TX, 8'hFF);
    wr(`OLT_ADDR_LOOP_COUNT, 8'h00);
    for (int i = 2; i < 9; i++) if (i != 5) rd(ra[i], 8'h00);
    $display("test clear done");
    {loop_stop_ind, long_loop_timer, reply_wait_timer} = 3'b111;
    fibre_link_down = 1'b1;
    wr(`OLT_ADDR_STATUS, 8'hD0);
    {loop_stop_ind, long_loop_timer, reply_wait_timer} = 3'b000;
    rd(`OLT_ADDR_STATUS, 8'h9F);
    rd(`OLT_ADDR_STATUS, 8'h91);
    reply_wait_timer = 1'b1;
    rd(`OLT_ADDR_STATUS, 8'h91);
    reply_wait_timer = 1'b0;
    rd(`OLT_ADDR_STATUS, 8'h93);
    $display("test status done");
    center_side = 1'b0;
    fi = 0;
    wr(`OLT_ADDR_LOOP_COUNT, 8'h01);
    repeat (40) tick();
    chk({fi[7:0], 7'd0, loop_busy}, 16'h0000, "terminal burst");
    $display("test terminal side done");
    ce = 1'b0;
    wr(`OLT_ADDR_LOOP_COUNT, 8'h05);
    ce = 1'b1;
    rd(`OLT_ADDR_LOOP_COUNT, 8'h01);
    $display("test clock enable done");
    test_done();
  end
endmodule : tb_olt_engine
